// ==== hw/bpcd_defines.svh ====
// Purpose: Offsets, field positions, reset values and codes of the boot window command decoder
// Assumes: Host word addresses on a 16-bit parallel bus
// Notes: Definitions only
`ifndef BPCD_DEFINES_SVH
`define BPCD_DEFINES_SVH

// ****************************************
// Host address map
// ****************************************
`define BPCD_BOOT_MAIN_LAST 16'h01ff
`define BPCD_BOOT_SPARE_FIRST 16'h8000
`define BPCD_BOOT_SPARE_LAST 16'h800f
`define BPCD_DATA0_FIRST 16'h0400
`define BPCD_DATA0_LAST 16'h07ff
`define BPCD_REG_BLOCK 16'hf100
`define BPCD_REG_PAGE 16'hf107
`define BPCD_REG_BUFSEL 16'hf200
`define BPCD_REG_WP 16'hf24e
`define BPCD_REG_ECC 16'hff00

// ****************************************
// Command words and identification addresses
// ****************************************
`define BPCD_CMD_RESET 16'h00f0
`define BPCD_CMD_LOAD 16'h00e0
`define BPCD_CMD_CONFIRM 16'h0000
`define BPCD_CMD_IDENT 16'h0090
`define BPCD_ID_MFR 16'h0000
`define BPCD_ID_DEV 16'h0001
`define BPCD_ID_WP 16'h0002
`define BPCD_BUSY_WORD 16'h0000

// ****************************************
// Sizes, field positions, reset values
// ****************************************
`define BPCD_PAGE_LAST_WORD 10'h3ff
`define BPCD_BOOT_SPARE_BASE 10'h200
`define BPCD_BOOT_WORDS 528
`define BPCD_DATA0_WORDS 1024
`define BPCD_WP_RESET 16'h0002
`define BPCD_PAGE_LSB 2
`define BPCD_BSA_LSB 8

// ****************************************
// Software port offsets
// ****************************************
`define BPCD_SW_WP 4'h0
`define BPCD_SW_ADDR 4'h1
`define BPCD_SW_STATE 4'h2
`define BPCD_SW_ECC 4'h3
`define BPCD_SW_BOOT_PTR 4'h4
`define BPCD_SW_BOOT_DATA 4'h5

`endif

// ==== hw/bpcd_pkg.sv ====
// Purpose: Types of the boot window command decoder
// Assumes: Nothing
// Notes: Constants live in bpcd_defines.svh
package bpcd_pkg;

  // ****************************************
  // Decoder states
  // ****************************************
  typedef enum logic [3:0] {
    BPCD_IDLE = 4'h1,
    BPCD_LOAD_ARMED = 4'h2,
    BPCD_IDENT = 4'h4,
    BPCD_LOADING = 4'h8
  } bpcd_state_t;

  // ****************************************
  // Core state
  // ****************************************
  typedef struct packed {
    bpcd_state_t state;
    logic [9:0] block;
    logic [5:0] page;
    logic [1:0] sector;
    logic [3:0] buf_sector;
    logic [1:0] buf_count;
    logic [15:0] ecc_status;
    logic [15:0] wp_status;
    logic [9:0] word_idx;
    logic [9:0] boot_ptr;
    logic we_q;
    logic clk_q;
    logic [15:0] burst_addr;
    logic burst_on;
    logic [15:0] dq;
    logic dq_oe;
    logic [15:0] rdata;
  } bpcd_core_t;

endpackage

// ==== hw/bpcd_pin_sync.sv ====
// Purpose: Two flip-flop synchroniser for the host pins
// Assumes: Inputs asynchronous to ref_clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module bpcd_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bpcd_sync_t;

  bpcd_sync_t st;
  bpcd_sync_t next_st;

  always_comb begin
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.s2;

endmodule

// ==== hw/bpcd_top.sv ====
// Purpose: Boot window command decoder with boot buffer, first data buffer and address registers
// Assumes: Host pins asynchronous, array port on ref_clk_i, software port on ref_clk_i
// Notes: Overview of operation follows
//
// Overview of operation
// - Command words are decoded only when written inside the boot window.
// - Boot window is 0000h-01FFh and 8000h-800Fh.
// - Boot reads give boot buffer only with no command pending, else command result.
// - Writes outside boot window are plain buffer or register stores.
// - Operation starts only after the last write of its sequence.
// - Bad command word or bad data in a sequence aborts to ready.
// - Writing 00F0h to the boot window in the ready state restores all defaults except protection status and boot pointer.
// - Writing 00E0h then 0000h loads one page into the first data buffer.
// - Each load moves a 2KB unit into the first data buffer.
// - Load ignores sector, buffer sector and buffer count fields.
// - After a load the page field increments by one.
// - Page increment wraps inside the block, never carries into block.
// - Block and page fields reset to zero.
// - After 0090h, reads give maker code, device code, protection status.
// - A write enable toggle ends identification.
// - Data buffer reads and writes are served directly.
// - Chip enable and address valid strobe low with output and write enable idle plus burst clock latches burst address.
// - Any command clears the error-correction status; here not while a load is running, and a same-cycle software write to it wins.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "bpcd_defines.svh"
module bpcd_top #(
  parameter logic [15:0] MFR_CODE = 16'h005a, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0011 // Arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic chip_enable_b_i,
  input wire logic output_enable_b_i,
  input wire logic write_enable_b_i,
  input wire logic address_valid_strobe_b_i,
  input wire logic burst_clk_i,
  input wire logic warm_reset_pin_b_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic array_req_o,
  output logic [9:0] array_block_o,
  output logic [5:0] array_page_o,
  input wire logic array_valid_i,
  input wire logic [15:0] array_data_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic busy_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [37:0] pins;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic avd_n;
  logic bclk;
  logic rp_n;
  logic [15:0] host_a;
  logic [15:0] host_d;

  bpcd_pin_sync #(
    .W(38),
    .RST_VAL({6'h3f, 32'h0})
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({chip_enable_b_i, output_enable_b_i, write_enable_b_i, address_valid_strobe_b_i,
              burst_clk_i, warm_reset_pin_b_i, addr_i, dq_i}),
    .sync_o(pins)
  );

  assign {ce_n, oe_n, we_n, avd_n, bclk, rp_n, host_a, host_d} = pins;

  // ****************************************
  // Buffers
  // ****************************************
  logic [15:0] boot_buffer [0:`BPCD_BOOT_WORDS-1];
  logic [15:0] first_data_buffer [0:`BPCD_DATA0_WORDS-1];

  function automatic logic in_boot(input logic [15:0] a);
    in_boot = (a <= `BPCD_BOOT_MAIN_LAST) ||
              (a >= `BPCD_BOOT_SPARE_FIRST && a <= `BPCD_BOOT_SPARE_LAST);
  endfunction

  function automatic logic in_data0(input logic [15:0] a);
    in_data0 = (a >= `BPCD_DATA0_FIRST) && (a <= `BPCD_DATA0_LAST);
  endfunction

  function automatic logic [9:0] boot_idx(input logic [15:0] a);
    boot_idx = a[15] ? (`BPCD_BOOT_SPARE_BASE | {6'h0, a[3:0]}) : {1'b0, a[8:0]};
  endfunction

  // ****************************************
  // Core state
  // ****************************************
  bpcd_pkg::bpcd_core_t core;
  bpcd_pkg::bpcd_core_t next_core;
  logic host_wr;
  logic boot_hit;
  logic clk_rise;
  logic load_word;
  logic load_last;
  logic defaults;
  logic sw_ecc_wr;
  logic sw_boot_wr;
  logic [15:0] ra;
  logic [15:0] rd_word;

  assign host_wr = core.we_q == 1'b0 && we_n && !ce_n && rp_n;
  assign boot_hit = in_boot(host_a);
  assign clk_rise = !core.clk_q && bclk;
  assign load_word = core.state == bpcd_pkg::BPCD_LOADING && array_valid_i;
  assign load_last = load_word && core.word_idx == `BPCD_PAGE_LAST_WORD;
  assign sw_ecc_wr = reg_wr_i && reg_addr_i == `BPCD_SW_ECC;
  assign sw_boot_wr = reg_wr_i && reg_addr_i == `BPCD_SW_BOOT_DATA;
  assign ra = core.burst_on ? core.burst_addr : host_a;

  // ****************************************
  // Host read data
  // ****************************************
  always_comb begin
    rd_word = 16'h0000;
    if (in_boot(ra)) begin
      if (core.state == bpcd_pkg::BPCD_IDENT) begin
        case (ra)
          `BPCD_ID_MFR: rd_word = MFR_CODE;
          `BPCD_ID_DEV: rd_word = DEV_CODE;
          `BPCD_ID_WP: rd_word = core.wp_status;
          default: rd_word = 16'h0000;
        endcase
      end else if (core.state == bpcd_pkg::BPCD_IDLE) begin
        rd_word = boot_buffer[boot_idx(ra)];
      end else begin
        rd_word = `BPCD_BUSY_WORD;
      end
    end else if (in_data0(ra)) begin
      rd_word = first_data_buffer[ra[9:0]];
    end else begin
      case (ra)
        `BPCD_REG_BLOCK: rd_word = {6'h00, core.block};
        `BPCD_REG_PAGE: rd_word = {8'h00, core.page, core.sector};
        `BPCD_REG_BUFSEL: rd_word = {4'h0, core.buf_sector, 6'h00, core.buf_count};
        `BPCD_REG_WP: rd_word = core.wp_status;
        `BPCD_REG_ECC: rd_word = core.ecc_status;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_core = core;
    defaults = !rp_n;
    next_core.we_q = we_n;
    next_core.clk_q = bclk;
    next_core.dq = rd_word;
    next_core.dq_oe = !ce_n && !oe_n && we_n && rp_n;
    // Burst address load and advance
    if (ce_n) begin
      next_core.burst_on = 1'b0;
    end else if (clk_rise && oe_n && we_n && !avd_n) begin
      next_core.burst_addr = host_a;
      next_core.burst_on = 1'b1;
    end else if (clk_rise && !oe_n && core.burst_on) begin
      next_core.burst_addr = core.burst_addr + 16'h0001;
    end
    // Command decoding inside the boot window
    if (host_wr && boot_hit && core.state != bpcd_pkg::BPCD_LOADING) begin
      next_core.ecc_status = 16'h0000;
      case (core.state)
        bpcd_pkg::BPCD_IDLE: begin
          if (host_d == `BPCD_CMD_RESET) begin
            defaults = 1'b1;
          end else if (host_d == `BPCD_CMD_LOAD) begin
            next_core.state = bpcd_pkg::BPCD_LOAD_ARMED;
          end else if (host_d == `BPCD_CMD_IDENT) begin
            next_core.state = bpcd_pkg::BPCD_IDENT;
          end else begin
            next_core.state = bpcd_pkg::BPCD_IDLE;
          end
        end
        bpcd_pkg::BPCD_LOAD_ARMED: begin
          if (host_d == `BPCD_CMD_CONFIRM) begin
            next_core.state = bpcd_pkg::BPCD_LOADING;
            next_core.word_idx = 10'h000;
          end else begin
            next_core.state = bpcd_pkg::BPCD_IDLE;
          end
        end
        default: begin
          next_core.state = bpcd_pkg::BPCD_IDLE;
        end
      endcase
    end else if (host_wr && !boot_hit) begin
      if (core.state == bpcd_pkg::BPCD_IDENT) begin
        next_core.state = bpcd_pkg::BPCD_IDLE;
      end
      case (host_a)
        `BPCD_REG_BLOCK: next_core.block = host_d[9:0];
        `BPCD_REG_PAGE: begin
          next_core.page = host_d[`BPCD_PAGE_LSB +: 6];
          next_core.sector = host_d[1:0];
        end
        `BPCD_REG_BUFSEL: begin
          next_core.buf_sector = host_d[`BPCD_BSA_LSB +: 4];
          next_core.buf_count = host_d[1:0];
        end
        default: next_core.block = core.block;
      endcase
    end
    // Page load from the array
    if (load_word) begin
      next_core.word_idx = core.word_idx + 10'h001;
      if (load_last) begin
        next_core.page = core.page + 6'h01;
        next_core.state = bpcd_pkg::BPCD_IDLE;
      end
    end
    // Software port
    if (reg_wr_i) begin
      case (reg_addr_i)
        `BPCD_SW_WP: next_core.wp_status = reg_wdata_i;
        `BPCD_SW_BOOT_PTR: next_core.boot_ptr = reg_wdata_i[9:0];
        `BPCD_SW_BOOT_DATA: next_core.boot_ptr = core.boot_ptr + 10'h001;
        default: next_core.boot_ptr = core.boot_ptr;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `BPCD_SW_WP: next_core.rdata = core.wp_status;
        `BPCD_SW_ADDR: next_core.rdata = {core.block, core.page};
        `BPCD_SW_STATE: next_core.rdata = {12'h000, core.state};
        `BPCD_SW_ECC: next_core.rdata = core.ecc_status;
        `BPCD_SW_BOOT_PTR: next_core.rdata = {6'h00, core.boot_ptr};
        default: next_core.rdata = 16'h0000;
      endcase
    end
    // Defaults from reset command or warm reset pin
    if (defaults) begin
      next_core.state = bpcd_pkg::BPCD_IDLE;
      next_core.block = 10'h000;
      next_core.page = 6'h00;
      next_core.sector = 2'h0;
      next_core.buf_sector = 4'h0;
      next_core.buf_count = 2'h0;
      next_core.ecc_status = 16'h0000;
      next_core.burst_on = 1'b0;
    end
    // Error status written by software wins over a clear
    if (sw_ecc_wr) begin
      next_core.ecc_status = reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core <= '{state: bpcd_pkg::BPCD_IDLE, block: 10'h000, page: 6'h00,
                sector: 2'h0, buf_sector: 4'h0, buf_count: 2'h0, ecc_status: 16'h0000,
                wp_status: `BPCD_WP_RESET, word_idx: 10'h000, boot_ptr: 10'h000,
                we_q: 1'b1, clk_q: 1'b1, burst_addr: 16'h0000, burst_on: 1'b0,
                dq: 16'h0000, dq_oe: 1'b0, rdata: 16'h0000};
    end else begin
      core <= next_core;
    end
  end

  // ****************************************
  // Buffer writes
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (load_word) begin
      first_data_buffer[core.word_idx] <= array_data_i;
    end else if (host_wr && in_data0(host_a)) begin
      first_data_buffer[host_a[9:0]] <= host_d;
    end
    if (sw_boot_wr) begin
      boot_buffer[core.boot_ptr] <= reg_wdata_i;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dq_o = core.dq;
  assign dq_oe_o = core.dq_oe;
  assign array_req_o = core.state == bpcd_pkg::BPCD_LOADING;
  assign array_block_o = core.block;
  assign array_page_o = core.page;
  assign reg_rdata_o = core.rdata;
  assign busy_o = core.state != bpcd_pkg::BPCD_IDLE;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_boot_cmd(logic [15:0] word);
    host_wr && boot_hit && !defaults && !sw_ecc_wr && host_d == word;
  endsequence

  sequence s_page_done;
    load_last && rp_n;
  endsequence

  a_outside_no_cmd: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    host_wr && !boot_hit && core.state == bpcd_pkg::BPCD_IDLE && rp_n |=> core.state == bpcd_pkg::BPCD_IDLE)
    else $error("write outside boot window changed decoder state");

  a_spare_edge: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    host_wr && host_a == `BPCD_BOOT_SPARE_LAST && host_d == `BPCD_CMD_LOAD &&
    core.state == bpcd_pkg::BPCD_IDLE && rp_n |=> core.state == bpcd_pkg::BPCD_LOAD_ARMED)
    else $error("last spare boot address not decoded");

  a_pending_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_LOAD_ARMED && in_boot(ra) |=> core.dq == `BPCD_BUSY_WORD)
    else $error("boot data returned while command pending");

  a_load_start: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_LOAD_ARMED ##0 s_boot_cmd(`BPCD_CMD_CONFIRM)
    |=> array_req_o && core.word_idx == 10'h000 ##1 array_req_o)
    else $error("load did not start after confirm word");

  a_seq_abort: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_LOAD_ARMED && host_wr && boot_hit && host_d != `BPCD_CMD_CONFIRM
    |=> core.state == bpcd_pkg::BPCD_IDLE && !array_req_o)
    else $error("bad second word did not abort");

  a_reset_cmd: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_IDLE ##0 s_boot_cmd(`BPCD_CMD_RESET)
    |=> core.block == 10'h000 && core.page == 6'h00 && core.ecc_status == 16'h0000)
    else $error("reset command left fields set");

  a_page_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    s_page_done |=> core.page == $past(core.page) + 6'h01 && core.block == $past(core.block) && !busy_o)
    else $error("page increment wrong after load");

  a_ecc_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    host_wr && boot_hit && !sw_ecc_wr && core.state != bpcd_pkg::BPCD_LOADING
    |=> core.ecc_status == 16'h0000)
    else $error("error status not cleared by command");

  a_ident_end: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_IDENT && host_wr |=> core.state == bpcd_pkg::BPCD_IDLE)
    else $error("write toggle did not end identification");

  a_ident_maker: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    core.state == bpcd_pkg::BPCD_IDENT && ra == `BPCD_ID_MFR |=> core.dq == MFR_CODE)
    else $error("maker code not returned");

  a_burst_latch: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    clk_rise && !ce_n && oe_n && we_n && !avd_n |=> core.burst_on && core.burst_addr == $past(host_a))
    else $error("burst address not latched");

endmodule

// ==== sim/bpcd_host_model.sv ====
// Purpose: Host processor model driving the parallel bus pins
// Assumes: Pins change just after a rising edge of ref_clk_i
// Notes: Burst clock stands still outside a burst; released bus shows inverse data
`timescale 1ns/100ps
module bpcd_host_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  output logic ce_b_o,
  output logic oe_b_o,
  output logic we_b_o,
  output logic avd_b_o,
  output logic bclk_o,
  output logic rp_b_o,
  output logic [15:0] addr_o,
  output logic [15:0] dq_o
);
  // ********
  // Idle pins
  // ********
  initial begin
    ce_b_o = 1'b1;
    oe_b_o = 1'b1;
    we_b_o = 1'b1;
    avd_b_o = 1'b1;
    bclk_o = 1'b0;
    rp_b_o = 1'b1;
    addr_o = 16'h0000;
    dq_o = 16'h0000;
  end

  // ********
  // Bus cycles
  // ********
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Address and data stand 4 clocks around the write enable rise
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    dq_o <= d;
    ce_b_o <= 1'b0;
    hold(4);
    we_b_o <= 1'b0;
    hold(4);
    we_b_o <= 1'b1;
    hold(4);
    ce_b_o <= 1'b1;
    dq_o <= ~d;
    hold(2);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(posedge ref_clk_i);
    addr_o <= a;
    ce_b_o <= 1'b0;
    oe_b_o <= 1'b0;
    hold(5);
    #1;
    d = dq_i;
    v = dq_oe_i;
    @(posedge ref_clk_i);
    oe_b_o <= 1'b1;
    ce_b_o <= 1'b1;
    addr_o <= ~a;
    hold(3);
  endtask

  // Latch a start address, read it, clock once, read the next word
  task automatic burst(input logic [15:0] a, output logic [15:0] d0, output logic [15:0] d1);
    @(posedge ref_clk_i);
    addr_o <= a;
    ce_b_o <= 1'b0;
    avd_b_o <= 1'b0;
    hold(4);
    bclk_o <= 1'b1;
    hold(4);
    bclk_o <= 1'b0;
    hold(4);
    avd_b_o <= 1'b1;
    addr_o <= ~a;
    oe_b_o <= 1'b0;
    hold(5);
    #1;
    d0 = dq_i;
    @(posedge ref_clk_i);
    bclk_o <= 1'b1;
    hold(4);
    bclk_o <= 1'b0;
    hold(4);
    #1;
    d1 = dq_i;
    @(posedge ref_clk_i);
    oe_b_o <= 1'b1;
    ce_b_o <= 1'b1;
    hold(3);
  endtask

  task automatic warm;
    @(posedge ref_clk_i);
    rp_b_o <= 1'b0;
    hold(6);
    rp_b_o <= 1'b1;
    hold(4);
  endtask
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench of the boot window command decoder
// Assumes: Host model on the pins, bench drives array and software port
// Notes: One task per scenario
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] MFR = 16'h0a5a; // Arbitrary value
  localparam logic [15:0] DEV = 16'h0033; // Arbitrary value
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_b, oe_b, we_b, avd_b, bclk, rp_b, dq_oe, array_req, busy;
  logic [15:0] addr, dq_w, dq_r, reg_rdata;
  logic [9:0] blk;
  logic [5:0] pg;
  logic array_valid_i = 1'b0;
  logic [15:0] array_data_i = 16'h0000;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  bpcd_host_model host (.ref_clk_i(ref_clk_i), .dq_i(dq_r), .dq_oe_i(dq_oe), .ce_b_o(ce_b), .oe_b_o(oe_b),
    .we_b_o(we_b), .avd_b_o(avd_b), .bclk_o(bclk), .rp_b_o(rp_b), .addr_o(addr), .dq_o(dq_w));

  bpcd_top #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .chip_enable_b_i(ce_b), .output_enable_b_i(oe_b), .write_enable_b_i(we_b),
    .address_valid_strobe_b_i(avd_b), .burst_clk_i(bclk), .warm_reset_pin_b_i(rp_b), .addr_i(addr),
    .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe), .array_req_o(array_req), .array_block_o(blk),
    .array_page_o(pg), .array_valid_i(array_valid_i), .array_data_i(array_data_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata),
    .busy_o(busy));

  // ********
  // Helpers
  // ********
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_r(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("register read", exp, reg_rdata);
  endtask

  task automatic hr(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    chk("host read", exp, d);
    chk("read drive", 16'h1, 16'(v));
  endtask

  task automatic st(input logic [15:0] b, input logic [15:0] r, input logic [15:0] k, input logic [15:0] p);
    chk("busy", b, 16'(busy));
    chk("array request", r, 16'(array_req));
    chk("block", k, 16'(blk));
    chk("page", p, 16'(pg));
  endtask

  // 1024 array words; the request must outlast the 1023rd
  task automatic feed;
    for (int i = 0; i < 1024; i++) begin
      if (i == 1023) begin
        @(posedge ref_clk_i);
        array_valid_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 chk("array request", 16'h1, 16'(array_req));
      end
      @(posedge ref_clk_i);
      array_valid_i <= 1'b1;
      array_data_i <= 16'hc3c3 ^ 16'(i);
    end
    @(posedge ref_clk_i);
    array_valid_i <= 1'b0;
    array_data_i <= 16'h3c3c;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    st(0, 0, 0, 0);
    reg_r(4'h0, 16'h0002);
    reg_r(4'h2, 16'h0001);
  endtask

  task automatic t_boot;
    reg_w(4'h4, 16'h0000);
    reg_w(4'h5, 16'h1234);
    reg_w(4'h4, 16'h0200);
    reg_w(4'h5, 16'habcd);
    reg_r(4'h4, 16'h0201);
    hr(16'h0000, 16'h1234);
    hr(16'h8000, 16'habcd);
    hr(16'h8010, 16'h0000);
  endtask

  task automatic t_outside;
    host.wr(16'h0200, 16'h0090);
    st(0, 0, 0, 0);
    host.wr(16'h8010, 16'h00e0);
    st(0, 0, 0, 0);
    host.wr(16'h0400, 16'h00e0);
    st(0, 0, 0, 0);
    hr(16'h0400, 16'h00e0);
  endtask

  task automatic t_abort;
    host.wr(16'h0000, 16'h00e0);
    st(1, 0, 0, 0);
    host.wr(16'h0001, 16'h1234);
    st(0, 0, 0, 0);
    host.wr(16'h0000, 16'h0077);
    st(0, 0, 0, 0);
  endtask

  task automatic t_load;
    host.wr(16'hf100, 16'h0003);
    host.wr(16'hf107, 16'h00fb);
    hr(16'hf107, 16'h00fb);
    host.wr(16'hf200, 16'h0f03);
    reg_w(4'h3, 16'hffff);
    host.wr(16'h800f, 16'h00e0);
    st(1, 0, 3, 62);
    reg_r(4'h3, 16'h0000);
    reg_r(4'h2, 16'h0002);
    hr(16'h0000, 16'h0000);
    host.wr(16'h01ff, 16'h0000);
    st(1, 1, 3, 62);
    feed();
    st(0, 0, 3, 63);
    reg_r(4'h1, 16'h00ff);
    hr(16'h0400, 16'hc3c3);
    hr(16'h07ff, 16'hc3c3 ^ 16'h03ff);
    host.wr(16'h0005, 16'h00e0);
    host.wr(16'h8002, 16'h0000);
    feed();
    st(0, 0, 3, 0);
  endtask

  task automatic t_burst;
    logic [15:0] d0, d1;
    host.burst(16'h0402, d0, d1);
    chk("burst first", 16'hc3c3 ^ 16'h0002, d0);
    chk("burst next", 16'hc3c3 ^ 16'h0003, d1);
  endtask

  task automatic t_ident;
    host.wr(16'hf100, 16'h0005);
    host.wr(16'h0100, 16'h0090);
    st(1, 0, 5, 0);
    hr(16'h0000, MFR);
    hr(16'h0001, DEV);
    hr(16'h0002, 16'h0002);
    host.wr(16'h0600, 16'h1111);
    st(0, 0, 5, 0);
    hr(16'h0000, 16'h1234);
  endtask

  task automatic t_resets;
    host.wr(16'hf107, 16'h0010);
    st(0, 0, 5, 4);
    host.wr(16'h0010, 16'h00f0);
    st(0, 0, 0, 0);
    host.wr(16'hf100, 16'h0009);
    st(0, 0, 9, 0);
    host.warm();
    st(0, 0, 0, 0);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    t_reset();
    t_boot();
    t_outside();
    t_abort();
    t_load();
    t_burst();
    t_ident();
    t_resets();
    report_and_stop();
  end

  // Whole run is under 10000 clocks
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule
